// ---- hdl/hrp_pkg.sv ----
`default_nettype none
package hrp_pkg;
  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_FMT  = 8'h30;  // Format select.
  localparam logic [7:0] IDX_PAT  = 8'h31;  // Pattern and filter control.
  localparam logic [7:0] IDX_DLY  = 8'h32;  // Output delay.
  localparam logic [7:0] IDX_SYNC = 8'h34;  // Sync input select.
  localparam logic [7:0] IDX_STAT = 8'h3f;  // Read-only status.
  // Reset values.
  localparam logic [7:0] RST_FMT  = 8'h00;
  localparam logic [7:0] RST_PAT  = 8'h00;
  localparam logic [7:0] RST_DLY  = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h40;
  // Writable bits; the others are reserved and read as zero.
  localparam logic [7:0] MSK_FMT  = 8'hff;
  localparam logic [7:0] MSK_PAT  = 8'hfd;
  localparam logic [7:0] MSK_DLY  = 8'h7e;
  localparam logic [7:0] MSK_SYNC = 8'h40;
  // Field positions.
  localparam int unsigned OSTD_LSB = 0;
  localparam int unsigned EMB_BIT  = 2;
  localparam int unsigned STD_LSB  = 3;
  localparam int unsigned PDV_BIT  = 0;
  localparam int unsigned TPE_BIT  = 2;
  localparam int unsigned FLAT_BIT = 3;
  localparam int unsigned DLYY_LSB = 1;
  localparam int unsigned DLYC_LSB = 4;
  localparam int unsigned VSEL_BIT = 6;
  // Codes.
  localparam logic [1:0] OSTD_RSV  = 2'h3;
  localparam logic [4:0] STD_RSV_A = 5'h01;
  localparam logic [4:0] STD_RSV_B = 5'h0b;
  localparam logic [4:0] STD_RSV_C = 5'h0c;
  localparam logic [4:0] STD_LAST  = 5'h12;
  localparam logic [2:0] DLY_MAX   = 3'h4;
  localparam int unsigned STAGES   = 4;
  // Video words.
  localparam int unsigned DW       = 10;
  localparam int unsigned CNT_W    = 11;
  localparam logic [9:0] Y_WHITE   = 10'h3ac;
  localparam logic [9:0] Y_BLACK   = 10'h040;
  localparam logic [9:0] C_MID     = 10'h200;
  localparam logic [9:0] TRS_ONES  = 10'h3ff;
  localparam logic [9:0] TRS_ZERO  = 10'h000;
  localparam logic [3:0] HATCH_ON  = 4'h0;
  // Timing code search states.
  typedef enum logic [1:0] {S_HUNT, S_ONES, S_ZERO1, S_ZERO2} hrp_trs_state_e;
endpackage
`default_nettype wire

// ---- hdl/hrp_timing_if.sv ----
`default_nettype none
// Timing levels recovered from embedded codes.
interface hrp_timing_if;
  logic hs;   // Horizontal blanking, high active.
  logic vs;   // Vertical blanking, high active.
  logic fld;  // Field identity.
  modport src (output hs, output vs, output fld);
  modport dst (input hs, input vs, input fld);
endinterface
`default_nettype wire

// ---- hdl/hrp_delay_line.sv ----
`default_nettype none
// Tapped delay of zero to four clock cycles.
module hrp_delay_line (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [9:0] din_i,
  input  wire logic [2:0] sel_i,
  output logic      [9:0] dout_o
);
  logic [9:0] tap [0:hrp_pkg::STAGES];  // Tap zero is the input itself.

  assign tap[0] = din_i;

  // ----------------------------------------------------------------
  // One register per stage.
  // ----------------------------------------------------------------
  for (genvar i = 1; i <= hrp_pkg::STAGES; i++) begin : g_stage
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tap[i] <= '0;
      end else if (ce_i) begin
        tap[i] <= tap[i-1];
      end
    end
  end

  // Codes above four are clamped so a bad write cannot pick a missing tap.
  always_comb begin
    if (sel_i > hrp_pkg::DLY_MAX) begin
      dout_o = tap[hrp_pkg::STAGES];
    end else begin
      dout_o = tap[sel_i];
    end
  end
endmodule // hrp_delay_line
`default_nettype wire

// ---- hdl/hrp_trs_decode.sv ----
`default_nettype none
// Recovers timing from the code words of the luma stream.
module hrp_trs_decode (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [9:0] y_i,
  hrp_timing_if.src       tm
);
  hrp_pkg::hrp_trs_state_e state_ff;  // Preamble search state.
  logic hs_ff;
  logic vs_ff;
  logic fld_ff;

  // ----------------------------------------------------------------
  // Preamble search and status word capture.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= hrp_pkg::S_HUNT;
    end else if (ce_i) begin
      case (state_ff)
        hrp_pkg::S_HUNT: state_ff <= (y_i == hrp_pkg::TRS_ONES) ? hrp_pkg::S_ONES
                                                                 : hrp_pkg::S_HUNT;
        hrp_pkg::S_ONES: state_ff <= (y_i == hrp_pkg::TRS_ZERO) ? hrp_pkg::S_ZERO1
                                                                 : hrp_pkg::S_HUNT;
        hrp_pkg::S_ZERO1: state_ff <= (y_i == hrp_pkg::TRS_ZERO) ? hrp_pkg::S_ZERO2
                                                                  : hrp_pkg::S_HUNT;
        default: state_ff <= hrp_pkg::S_HUNT;
      endcase
    end
  end

  // The status word only counts when its top bit is set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_ff  <= 1'b0;
      vs_ff  <= 1'b0;
      fld_ff <= 1'b0;
    end else if (ce_i && state_ff == hrp_pkg::S_ZERO2 && y_i[9]) begin
      fld_ff <= y_i[8];
      vs_ff  <= y_i[7];
      hs_ff  <= y_i[6];
    end
  end

  assign tm.hs  = hs_ff;
  assign tm.vs  = vs_ff;
  assign tm.fld = fld_ff;
endmodule // hrp_trs_decode
`default_nettype wire

// ---- hdl/hrp_mode_regs.sv ----
// Notes on behaviour
// - Low two bits pick output level standard.
// - Bit 2 picks external sync or codes.
// - External sync uses HSYNC plus VSYNC or field.
// - Upper five bits pick input video standard.
// - Further codes pick 1035i/1080i/1080p; some reserved.
// - Second register bit 0 enables pixel-valid.
// - Second register bit 2 enables test pattern.
// - Bit 3 picks hatch or flat pattern.
// - Luma delayed zero to four cycles.
// - Chroma delayed zero to four, independently.
`default_nettype none
module hrp_mode_regs (
  input  wire logic        clk_i,        // System clock.
  input  wire logic        rst_i,        // Synchronous reset.
  input  wire logic        ce_i,         // Freezes all state when low.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [9:0]  pix_y_i,      // Luma pins.
  input  wire logic [9:0]  pix_c_i,      // Chroma pins.
  input  wire logic        pix_valid_i,  // Pixel data valid pin.
  input  wire logic        hsync_n_i,    // Horizontal sync pin, low active.
  input  wire logic        vsync_i,      // Vertical sync pin.
  input  wire logic        field_i,      // Field pin.
  output logic      [9:0]  y_o,
  output logic      [9:0]  c_o,
  output logic             hsync_o,
  output logic             vsync_o,
  output logic             field_o,
  output logic      [1:0]  out_std_o,
  output logic      [4:0]  std_code_o,
  output logic             std_bad_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  logic [7:0] fmt_ff;       // Format select register.
  logic [7:0] pat_ff;       // Pattern and filter control register.
  logic [7:0] dly_ff;       // Output delay register.
  logic [7:0] sync_ff;      // Sync input select register.
  logic       ack_ff;       // Bus acknowledge.
  logic [7:0] rd_ff;        // Registered read byte.
  logic       req;          // Bus request seen.
  logic       wr_go;        // Write commits this edge.
  logic [7:0] idx;          // Register index from the address.
  logic [7:0] nxt_rd;       // Read mux.
  logic [9:0] y_s1_ff, y_s2_ff, c_s1_ff, c_s2_ff;
  logic [4:0] ctl_s1_ff, ctl_s2_ff;  // Valid, hsync_n, vsync, field.
  logic       fld_d_ff;     // Previous field level.
  logic [9:0] y_cap_ff;     // Accepted luma sample.
  logic [9:0] c_cap_ff;     // Accepted chroma sample.
  logic [9:0] y_src;        // Luma before delay.
  logic [9:0] c_src;        // Chroma before delay.
  logic [9:0] y_dly, c_dly;
  logic       hs_ext, vs_ext, fld_ext;
  logic       hs_sel, vs_sel, fld_sel;
  logic       hs_d_ff, vs_d_ff;
  logic [hrp_pkg::CNT_W-1:0] hcnt_ff, lcnt_ff;
  logic       hatch_on;
  logic       std_rsv;
  logic       ostd_rsv;
  logic [4:0] std;

  hrp_timing_if tm ();

  // ----------------------------------------------------------------
  // Wishbone slave.
  // ----------------------------------------------------------------
  assign req   = wb_cyc_i && wb_stb_i;
  assign idx   = {2'h0, wb_adr_i[7:2]};
  // A write lands on the edge where the master sees ack.
  assign wr_go = ce_i && req && ack_ff && wb_we_i && wb_sel_i[0];

  // Ack rises one edge after the request and drops the edge after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= req && !ack_ff;
    end
  end

  // Unmapped indices read as zero and ignore writes.
  always_comb begin
    nxt_rd = 8'h00;
    case (idx)
      hrp_pkg::IDX_FMT:  nxt_rd = fmt_ff;
      hrp_pkg::IDX_PAT:  nxt_rd = pat_ff;
      hrp_pkg::IDX_DLY:  nxt_rd = dly_ff;
      hrp_pkg::IDX_SYNC: nxt_rd = sync_ff;
      hrp_pkg::IDX_STAT: nxt_rd = {3'h0, fld_sel, vs_sel, hs_sel, ostd_rsv, std_rsv};
      default:           nxt_rd = 8'h00;
    endcase
  end

  // Read data is caught with the ack so it is stable when sampled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ff <= 8'h00;
    end else if (ce_i && req && !ack_ff) begin
      rd_ff <= nxt_rd;
    end
  end

  assign wb_dat_o = {24'h0, rd_ff};
  assign wb_ack_o = ack_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fmt_ff  <= hrp_pkg::RST_FMT;
      pat_ff  <= hrp_pkg::RST_PAT;
      dly_ff  <= hrp_pkg::RST_DLY;
      sync_ff <= hrp_pkg::RST_SYNC;
    end else if (wr_go) begin
      case (idx)
        hrp_pkg::IDX_FMT:  fmt_ff  <= wb_dat_i[7:0] & hrp_pkg::MSK_FMT;
        hrp_pkg::IDX_PAT:  pat_ff  <= wb_dat_i[7:0] & hrp_pkg::MSK_PAT;
        hrp_pkg::IDX_DLY:  dly_ff  <= wb_dat_i[7:0] & hrp_pkg::MSK_DLY;
        hrp_pkg::IDX_SYNC: sync_ff <= wb_dat_i[7:0] & hrp_pkg::MSK_SYNC;
        default: begin
        end
      endcase
    end
  end

  chk_reset_zero: assert property ($past(rst_i) |-> fmt_ff == 8'h00 &&
    pat_ff == 8'h00 && dly_ff == 8'h00)
    else $error("Mode registers not zero after reset.");

  chk_ack_pulse: assert property (req && !ack_ff && ce_i |=> ack_ff ##1 !ack_ff)
    else $error("Bus ack is not a single-cycle answer.");

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  // Every pin passes two flops; only the second stage is read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      y_s1_ff   <= '0;
      y_s2_ff   <= '0;
      c_s1_ff   <= '0;
      c_s2_ff   <= '0;
      ctl_s1_ff <= 5'h02;
      ctl_s2_ff <= 5'h02;
    end else if (ce_i) begin
      y_s1_ff   <= pix_y_i;
      y_s2_ff   <= y_s1_ff;
      c_s1_ff   <= pix_c_i;
      c_s2_ff   <= c_s1_ff;
      ctl_s1_ff <= {1'b0, field_i, vsync_i, hsync_n_i, pix_valid_i};
      ctl_s2_ff <= ctl_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Timing source selection.
  // ----------------------------------------------------------------
  hrp_trs_decode u_trs (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .y_i   (y_s2_ff),
    .tm    (tm.src)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fld_d_ff <= 1'b0;
    end else if (ce_i) begin
      fld_d_ff <= ctl_s2_ff[3];
    end
  end

  // VSYNC or field pin
  // In field mode a field change stands in for the vertical edge.
  assign hs_ext  = !ctl_s2_ff[1];
  assign vs_ext  = sync_ff[hrp_pkg::VSEL_BIT] ? ctl_s2_ff[2]
                                              : (ctl_s2_ff[3] != fld_d_ff);
  assign fld_ext = sync_ff[hrp_pkg::VSEL_BIT] ? 1'b0 : ctl_s2_ff[3];

  assign hs_sel  = fmt_ff[hrp_pkg::EMB_BIT] ? tm.hs  : hs_ext;
  assign vs_sel  = fmt_ff[hrp_pkg::EMB_BIT] ? tm.vs  : vs_ext;
  assign fld_sel = fmt_ff[hrp_pkg::EMB_BIT] ? tm.fld : fld_ext;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      field_o <= 1'b0;
    end else if (ce_i) begin
      hsync_o <= hs_sel;
      vsync_o <= vs_sel;
      field_o <= fld_sel;
    end
  end

  chk_ext_hsync: assert property ((ce_i && !fmt_ff[hrp_pkg::EMB_BIT])[*2]
    |-> hsync_o == !$past(ctl_s2_ff[1]))
    else $error("External hsync not passed through.");

  chk_vsync_pin: assert property ((ce_i && !fmt_ff[hrp_pkg::EMB_BIT] &&
    sync_ff[hrp_pkg::VSEL_BIT])[*2] |-> vsync_o == $past(ctl_s2_ff[2]))
    else $error("Vsync pin not followed in vsync mode.");

  // ----------------------------------------------------------------
  // Pattern counters.
  // ----------------------------------------------------------------
  // Lines start at the sync's leading edge, frames at vertical start.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_d_ff <= 1'b0;
      vs_d_ff <= 1'b0;
      hcnt_ff <= '0;
      lcnt_ff <= '0;
    end else if (ce_i) begin
      hs_d_ff <= hs_sel;
      vs_d_ff <= vs_sel;
      hcnt_ff <= (hs_sel && !hs_d_ff) ? '0 : hcnt_ff + 1'b1;
      if (vs_sel && !vs_d_ff) begin
        lcnt_ff <= '0;
      end else if (hs_sel && !hs_d_ff) begin
        lcnt_ff <= lcnt_ff + 1'b1;
      end
    end
  end

  assign hatch_on = hcnt_ff[3:0] == hrp_pkg::HATCH_ON || lcnt_ff[3:0] == hrp_pkg::HATCH_ON;

  // ----------------------------------------------------------------
  // Video capture and source.
  // ----------------------------------------------------------------
  // pixel data valid gate
  // With the gate on, invalid samples repeat the last good one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      y_cap_ff <= hrp_pkg::Y_BLACK;
      c_cap_ff <= hrp_pkg::C_MID;
    end else if (ce_i && (!pat_ff[hrp_pkg::PDV_BIT] || ctl_s2_ff[0])) begin
      y_cap_ff <= y_s2_ff;
      c_cap_ff <= c_s2_ff;
    end
  end

  chk_pdv_hold: assert property (ce_i && pat_ff[hrp_pkg::PDV_BIT] && !ctl_s2_ff[0]
    |=> y_cap_ff == $past(y_cap_ff) && c_cap_ff == $past(c_cap_ff))
    else $error("Invalid pixel was taken with valid gate on.");

  always_comb begin
    y_src = y_cap_ff;
    c_src = c_cap_ff;
    if (pat_ff[hrp_pkg::TPE_BIT]) begin
      c_src = hrp_pkg::C_MID;
      if (pat_ff[hrp_pkg::FLAT_BIT]) begin
        y_src = hrp_pkg::Y_WHITE;
      end else begin
        y_src = hatch_on ? hrp_pkg::Y_WHITE : hrp_pkg::Y_BLACK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output delays and registers.
  // ----------------------------------------------------------------
  // luma delay taps
  hrp_delay_line u_dly_y (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .din_i  (y_src),
    .sel_i  (dly_ff[hrp_pkg::DLYY_LSB +: 3]),
    .dout_o (y_dly)
  );

  hrp_delay_line u_dly_c (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .din_i  (c_src),
    .sel_i  (dly_ff[hrp_pkg::DLYC_LSB +: 3]),
    .dout_o (c_dly)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      y_o <= hrp_pkg::Y_BLACK;
      c_o <= hrp_pkg::C_MID;
    end else if (ce_i) begin
      y_o <= y_dly;
      c_o <= c_dly;
    end
  end

  chk_luma_four: assert property ((ce_i && dly_ff[3:1] == 3'h4)[*6]
    |-> y_o == $past(y_src, 5))
    else $error("Luma delay of four cycles wrong.");

  chk_chroma_zero: assert property ((ce_i && dly_ff[6:4] == 3'h0)[*2]
    |-> c_o == $past(c_src))
    else $error("Chroma delay of zero cycles wrong.");

  chk_flat_out: assert property ((ce_i && pat_ff[3:2] == 2'h3 && dly_ff[6:1] == 6'h00)[*3]
    |-> y_o == hrp_pkg::Y_WHITE && c_o == hrp_pkg::C_MID)
    else $error("Flat pattern not on outputs.");

  // ----------------------------------------------------------------
  // Standard selection outputs.
  // ----------------------------------------------------------------
  // five-bit standard code
  assign std      = fmt_ff[hrp_pkg::STD_LSB +: 5];
  assign std_rsv  = std == hrp_pkg::STD_RSV_A || std == hrp_pkg::STD_RSV_B ||
                    std == hrp_pkg::STD_RSV_C || std > hrp_pkg::STD_LAST;
  assign ostd_rsv = fmt_ff[hrp_pkg::OSTD_LSB +: 2] == hrp_pkg::OSTD_RSV;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_std_o  <= 2'h0;
      std_code_o <= 5'h00;
      std_bad_o  <= 1'b0;
    end else if (ce_i) begin
      out_std_o  <= fmt_ff[hrp_pkg::OSTD_LSB +: 2];
      std_code_o <= std;
      std_bad_o  <= std_rsv;
    end
  end

  sequence s_fmt_write;
    wr_go && idx == hrp_pkg::IDX_FMT;
  endsequence

  // The register lands on the write edge and the output flop takes it one edge later.
  sequence s_applied;
    ce_i ##1 ce_i ##1 1'b1;
  endsequence

  chk_fmt_apply: assert property (s_fmt_write ##0 s_applied |->
    out_std_o == $past(wb_dat_i[1:0], 2) && std_code_o == $past(wb_dat_i[7:3], 2))
    else $error("Format write did not reach outputs.");

  chk_std_flag: assert property (s_fmt_write ##1 ce_i |=> std_bad_o ==
    ($past(wb_dat_i[7:3], 2) > 5'h12 || $past(wb_dat_i[7:3], 2) == 5'h0b ||
     $past(wb_dat_i[7:3], 2) == 5'h0c || $past(wb_dat_i[7:3], 2) == 5'h01))
    else $error("Reserved standard flag wrong.");
endmodule // hrp_mode_regs
`default_nettype wire

// ---- sim/hrp_video_src.sv ----
`default_nettype none
// Upstream source: a ramp on both buses, 32-pixel lines, 8-line frames.
module hrp_video_src (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       emb_i,      // High: timing as codes in the luma words.
  input  wire logic       gap_i,      // High: valid withheld, as a slow source does.
  output logic      [9:0] pix_y_o,
  output logic      [9:0] pix_c_o,
  output logic            valid_o,
  output logic            hsync_n_o,
  output logic            vsync_o,
  output logic            field_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cnt_ff;  // Free pixel counter.
  logic [4:0] px;      // Pixel within the line.
  logic [9:0] xyz;     // Timing word of the current code.
  // A ramp makes every delay measurable as a plain lag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 10'h000;
    end else begin
      cnt_ff <= cnt_ff + 10'h001;
    end
  end
  assign px  = cnt_ff[4:0];
  assign xyz = {1'b1, cnt_ff[7], cnt_ff[7:5] == 3'h0, px >= 5'h1c, 6'h00};
  assign hsync_n_o = emb_i | (px > 5'h03);
  assign vsync_o   = !emb_i && cnt_ff[7:5] == 3'h0;
  assign field_o   = !emb_i && cnt_ff[7];
  assign valid_o   = !gap_i;
  assign pix_c_o   = ~cnt_ff;
  // Codes sit at pixels 28..31 (end) and 4..7 (start); the ramp never forms one.
  always_comb begin
    pix_y_o = cnt_ff;
    if (emb_i && px[1:0] == 2'h0 && (px[4:2] == 3'h7 || px[4:2] == 3'h1)) pix_y_o = 10'h3ff;
    if (emb_i && (px[1:0] == 2'h1 || px[1:0] == 2'h2) && (px[4:2] == 3'h7 || px[4:2] == 3'h1))
      pix_y_o = 10'h000;
    if (emb_i && px[1:0] == 2'h3 && (px[4:2] == 3'h7 || px[4:2] == 3'h1)) pix_y_o = xyz;
  end
endmodule // hrp_video_src
`default_nettype wire

// ---- sim/test_hrp_mode_regs.sv ----
`default_nettype none
module test_hrp_mode_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, emb = 1'b0, gap = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h40;
  logic [9:0] pix_y_i, pix_c_i, y_o, c_o;
  logic pix_valid_i, hsync_n_i, vsync_i, field_i, hsync_o, vsync_o, field_o, std_bad_o;
  logic [1:0] out_std_o;
  logic [4:0] std_code_o;
  logic [9:0] r_p [5][512];  // Pins, as seen after each edge.
  logic [9:0] r_o [5][512];  // Outputs, as seen after each edge.
  int mismatches = 0, n_checks = 0, cyc = 0;
  always #20 clk_i = ~clk_i;
  hrp_video_src hrp_video_src_inst (.clk_i(clk_i), .rst_i(rst_i), .emb_i(emb), .gap_i(gap),
    .pix_y_o(pix_y_i), .pix_c_o(pix_c_i), .valid_o(pix_valid_i), .hsync_n_o(hsync_n_i),
    .vsync_o(vsync_i), .field_o(field_i));
  hrp_mode_regs hrp_mode_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pix_y_i(pix_y_i), .pix_c_i(pix_c_i), .pix_valid_i(pix_valid_i), .hsync_n_i(hsync_n_i),
    .vsync_i(vsync_i), .field_i(field_i), .y_o(y_o), .c_o(c_o), .hsync_o(hsync_o),
    .vsync_o(vsync_o), .field_o(field_o), .out_std_o(out_std_o), .std_code_o(std_code_o),
    .std_bad_o(std_bad_o));
  // Record pins and outputs so that lags can be measured afterwards.
  always @(posedge clk_i) begin
    #1;
    cyc++;
    r_p[0][cyc[8:0]] = {9'h0, ~hsync_n_i};
    r_p[1][cyc[8:0]] = {9'h0, vsync_i};
    r_p[2][cyc[8:0]] = {9'h0, field_i};
    r_p[3][cyc[8:0]] = pix_y_i;
    r_p[4][cyc[8:0]] = pix_c_i;
    r_o[0][cyc[8:0]] = {9'h0, hsync_o};
    r_o[1][cyc[8:0]] = {9'h0, vsync_o};
    r_o[2][cyc[8:0]] = {9'h0, field_o};
    r_o[3][cyc[8:0]] = y_o;
    r_o[4][cyc[8:0]] = c_o;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Reserved standard codes: 0x01, 0x0b, 0x0c and everything above 0x12.
  function automatic logic bad_std(input logic [4:0] s);
    return s == 5'h01 || s == 5'h0b || s == 5'h0c || s > 5'h12;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
                    input logic [3:0] sel, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {4{d}};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 40) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, 4'h1, q);
  endtask
  // Lag in cycles at which an output repeats its pin over 300 samples.
  task automatic lag(input int s, output int k);
    int t, j, i, ok;
    k = -1;
    for (j = 12; j >= 0; j--) begin
      ok = 1;
      for (t = 0; t < 300; t++) begin
        i = cyc - t - j;
        if (r_o[s][(cyc - t) % 512] !== r_p[s][i[8:0]]) ok = 0;
      end
      if (ok == 1) k = j;
    end
  endtask
  task automatic settle();
    repeat (320) @(posedge clk_i);
    #2;
  endtask
  initial begin
    logic [31:0] q;
    logic [7:0] adr [5] = '{8'hc0, 8'hc4, 8'hc8, 8'hd0, 8'hd4};
    logic [7:0] msk [5] = '{8'hff, 8'hfd, 8'h7e, 8'h40, 8'h00};
    logic [7:0] sh [5] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
    logic [9:0] v;
    int i, k, w, b, n;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 5; i++) begin
      wb(1'b0, adr[i], 8'h00, 4'h1, q);
      check("reset value", q, {24'h0, sh[i]});
    end
    $display("test reset done");
    for (i = 0; i < 32; i++) begin
      wr(8'hc0, {i[4:0], 1'b0, i[1:0]});
      repeat (3) @(posedge clk_i);
      #1;
      check("out_std_o", out_std_o, i[1:0]);
      check("std_code_o", std_code_o, i[4:0]);
      check("std_bad_o", std_bad_o, bad_std(i[4:0]));
      wb(1'b0, 8'hfc, 8'h00, 4'h1, q);
      check("status", q[1:0], {i[1:0] == 2'h3, bad_std(i[4:0])});
    end
    $display("test standards done");
    wr(8'hc0, 8'h00);
    for (n = 0; n < 40; n++) begin
      q = xs();
      i = q[10:8] % 5;
      if (q[12] && i < 4) sh[i] = q[7:0];
      wb(1'b1, adr[i], q[7:0], {3'h0, q[12]}, q);
      wb(1'b0, adr[i], 8'h00, 4'h1, q);
      check("readback", q, {24'h0, sh[i] & msk[i]});
    end
    $display("test readback done");
    wr(8'hc0, 8'h00);
    wr(8'hc4, 8'h00);
    wr(8'hd0, 8'h40);
    for (i = 0; i < 8; i++) begin
      wr(8'hc8, {1'b0, 3'(7 - i), i[2:0], 1'b0});
      settle();
      lag(3, k);
      check("luma lag", k, 4 + (i > 4 ? 4 : i));
      lag(4, k);
      check("chroma lag", k, 4 + (i < 3 ? 4 : 7 - i));
    end
    $display("test delays done");
    lag(0, k);
    check("hsync lag", k, 3);
    lag(1, k);
    check("vsync lag", k, 3);
    wr(8'hd0, 8'h00);
    settle();
    lag(2, k);
    check("field lag", k, 3);
    emb <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(8'hc0, {5'h00, ~i[0], 2'h0});
      settle();
      n = 0;
      for (k = 0; k < 64; k++) n += r_o[0][(cyc - k) % 512];
      check("embedded hsync", n, i == 0 ? 16 : 0);
    end
    emb <= 1'b0;
    $display("test sync done");
    wr(8'hc8, 8'h00);
    for (i = 0; i < 2; i++) begin
      wr(8'hc4, i == 0 ? 8'h0c : 8'h04);
      settle();
      w = 0;
      b = 0;
      for (k = 0; k < 64; k++) begin
        w += r_o[3][(cyc - k) % 512] === hrp_pkg::Y_WHITE;
        b += r_o[3][(cyc - k) % 512] === hrp_pkg::Y_BLACK;
      end
      check("chroma pattern", c_o, hrp_pkg::C_MID);
      check("pattern luma", {w == 64, w + b == 64, w > 0 && b > 0}, i == 0 ? 3'h6 : 3'h3);
    end
    $display("test pattern done");
    for (i = 0; i < 2; i++) begin
      wr(8'hc4, {7'h00, ~i[0]});
      @(posedge clk_i);
      gap <= 1'b1;
      repeat (12) @(posedge clk_i);
      #1;
      v = y_o;
      repeat (10) @(posedge clk_i);
      #1;
      check("held luma", y_o === v, i == 0);
      gap <= 1'b0;
    end
    $display("test valid done");
    final_report();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    final_report();
  end
endmodule // test_hrp_mode_regs
`default_nettype wire
